// ---- aod_pkg.sv ----
// Constants and types for the auxiliary output drive control block.
// Assumes a 32-bit APB master and factory sequencing straps held steady.
// Behaviour
// R1 - Drive style: off, battery-neg, ground, push-pull
// R2 - Style off keeps pin high impedance
// R3 - Sequencing code 101/110 makes pin-controllable part
// R4 - Asserted: neg, hi-z, neg per style
// R5 - Deasserted: hi-z, ground, ground per style
// R6 - Control bit1 clear: bit0 alone asserts
// R7 - Bit1 set: follow pin, bit0 picks polarity
// R8 - Non-capable part: pin never affects output
// R9 - Pin synchronised; output updates within cycles
package aod_pkg;

  // Register byte offsets
  localparam logic [7:0] AOD_CFG_OFS = 8'h00;
  localparam logic [7:0] AOD_STRAP_OFS = 8'h04;
  localparam logic [7:0] AOD_STAT_OFS = 8'h08;

  // aux_output_config fields
  localparam int AOD_STYLE_LSB = 0;
  localparam int AOD_CTL_LSB = 2;
  localparam logic [3:0] AOD_CFG_RST = 4'h0;

  // Status fields
  localparam int AOD_ST_PIN_LO = 0;
  localparam int AOD_ST_PIN_OE = 1;
  localparam int AOD_ST_ASSERT = 2;
  localparam int AOD_ST_AUXIN = 3;
  localparam int AOD_ST_CAPABLE = 4;

  // Sequencing codes that hand a rail to the control input
  localparam logic [2:0] AOD_SEQ_PIN_LOW = 3'h5;
  localparam logic [2:0] AOD_SEQ_PIN_HIGH = 3'h6;
  localparam int AOD_SEQ_W = 3;

  // Reset values of the output and bus flops
  localparam logic AOD_PIN_OE_RST = 1'b0;
  localparam logic AOD_PIN_LO_RST = 1'b0;
  localparam logic [31:0] AOD_RDATA_RST = 32'h0000_0000;

  // Synchroniser depth in flops
  localparam int AOD_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    AOD_STYLE_OFF = 2'b00,
    AOD_STYLE_NEG = 2'b01,
    AOD_STYLE_GND = 2'b10,
    AOD_STYLE_PP = 2'b11
  } aod_style_e;

endpackage : aod_pkg

// ---- aod_pin_sync.sv ----
// Three-flop synchroniser with agreement filter for the control input.
// Assumes the pin is asynchronous to i_ref_clk.
`timescale 1ns/1ps
module aod_pin_sync
  import aod_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_pin,
  output logic o_level
);

  logic [AOD_SYNC_STAGES-1:0] stage_reg;
  logic [AOD_SYNC_STAGES-1:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    stage_next = {stage_reg[AOD_SYNC_STAGES-2:0], i_pin};
    // Only the second and third flops are compared
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg; // R9
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;

endmodule : aod_pin_sync

// ---- aod_output_ctrl.sv ----
// Drive control for the level-shifted multipurpose output, with an APB
// register slave. Assumes the sequencing straps are static while running
// and the control input pin may change at any time.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module aod_output_ctrl
  import aod_pkg::*;
#(
  parameter int N_SWITCHER = 2,
  parameter int N_LINREG = 2,
  parameter int ADDR_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Factory sequencing straps
  input wire logic [N_SWITCHER*AOD_SEQ_W-1:0] i_switcher_seq_sel,
  input wire logic [N_LINREG*AOD_SEQ_W-1:0] i_linreg_seq_sel,
  // Control input pin
  input wire logic i_aux_control_input,
  // Multipurpose output: level low pulls to battery_neg_rail, high to ground
  output logic o_multipurpose_output_o,
  output logic o_multipurpose_output_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic is_pin_seq(input logic [AOD_SEQ_W-1:0] code);
    is_pin_seq = (code == AOD_SEQ_PIN_LOW) || (code == AOD_SEQ_PIN_HIGH); // R3
  endfunction : is_pin_seq

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] ofs);
    addr_hit = (addr == ADDR_W'(ofs));
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////
  // Control input synchroniser

  logic aux_in_level;

  aod_pin_sync u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_aux_control_input),
    .o_level(aux_in_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release

  logic [N_SWITCHER+N_LINREG-1:0] field_hit;
  logic captured_reg;
  logic captured_next;
  logic capable_reg;
  logic capable_next;
  logic [N_SWITCHER*AOD_SEQ_W-1:0] sw_seq_reg;
  logic [N_SWITCHER*AOD_SEQ_W-1:0] sw_seq_next;
  logic [N_LINREG*AOD_SEQ_W-1:0] lr_seq_reg;
  logic [N_LINREG*AOD_SEQ_W-1:0] lr_seq_next;

  genvar gi;
  generate
    for (gi = 0; gi < N_SWITCHER; gi++) begin : g_sw
      assign field_hit[gi] = is_pin_seq(i_switcher_seq_sel[gi*AOD_SEQ_W +: AOD_SEQ_W]);
    end
    for (gi = 0; gi < N_LINREG; gi++) begin : g_lr
      assign field_hit[N_SWITCHER+gi] =
        is_pin_seq(i_linreg_seq_sel[gi*AOD_SEQ_W +: AOD_SEQ_W]);
    end
  endgenerate

  always_comb begin
    captured_next = 1'b1;
    capable_next = capable_reg;
    sw_seq_next = sw_seq_reg;
    lr_seq_next = lr_seq_reg;
    if (!captured_reg) begin
      capable_next = |field_hit; // R3
      sw_seq_next = i_switcher_seq_sel;
      lr_seq_next = i_linreg_seq_sel;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      captured_reg <= 1'b0;
      capable_reg <= 1'b0;
      sw_seq_reg <= '0;
      lr_seq_reg <= '0;
    end else begin
      captured_reg <= captured_next;
      capable_reg <= capable_next;
      sw_seq_reg <= sw_seq_next;
      lr_seq_reg <= lr_seq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave and aux_output_config

  logic [3:0] cfg_reg;
  logic [3:0] cfg_next;
  logic pready_reg;
  logic pready_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] rd_mux;
  logic mapped;
  logic [4:0] status;

  always_comb begin
    mapped = addr_hit(i_paddr, AOD_CFG_OFS) || addr_hit(i_paddr, AOD_STRAP_OFS)
             || addr_hit(i_paddr, AOD_STAT_OFS);
    rd_mux = '0;
    if (addr_hit(i_paddr, AOD_CFG_OFS)) begin
      rd_mux = {28'h0, cfg_reg};
    end else if (addr_hit(i_paddr, AOD_STRAP_OFS)) begin
      rd_mux[N_SWITCHER*AOD_SEQ_W-1:0] = sw_seq_reg;
      rd_mux[16 +: N_LINREG*AOD_SEQ_W] = lr_seq_reg;
    end else if (addr_hit(i_paddr, AOD_STAT_OFS)) begin
      rd_mux = {27'h0, status};
    end
  end

  always_comb begin
    cfg_next = cfg_reg;
    pready_next = 1'b0;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    // One wait state: pready rises in the second access cycle
    if (i_psel && i_penable && !pready_reg) begin
      pready_next = 1'b1;
      pslverr_next = !mapped;
      prdata_next = i_pwrite ? '0 : rd_mux;
    end
    // Write takes effect at the completing edge
    if (i_psel && i_penable && pready_reg && i_pwrite && i_pstrb[0]
        && addr_hit(i_paddr, AOD_CFG_OFS)) begin
      cfg_next = i_pwdata[3:0]; // R1
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= AOD_CFG_RST;
      pready_reg <= 1'b0;
      prdata_reg <= AOD_RDATA_RST;
      pslverr_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertion source and pin drive

  aod_style_e style;
  logic [1:0] ctl;
  logic asserted;
  logic pin_lo_reg;
  logic pin_lo_next;
  logic pin_oe_reg;
  logic pin_oe_next;

  always_comb begin
    style = aod_style_e'(cfg_reg[AOD_STYLE_LSB +: 2]);
    ctl = cfg_reg[AOD_CTL_LSB +: 2];
    if (ctl[1] && capable_reg) begin
      // Bit0 clear: assert while pin low; set: while pin high
      asserted = ctl[0] ? aux_in_level : !aux_in_level; // R7
    end else begin
      asserted = ctl[0]; // R6 R8
    end
  end

  always_comb begin
    pin_lo_next = 1'b0;
    pin_oe_next = 1'b0;
    case (style)
      AOD_STYLE_OFF: begin
        pin_oe_next = 1'b0; // R2
      end
      AOD_STYLE_NEG: begin
        pin_oe_next = asserted; // R4 R5
        pin_lo_next = 1'b0;
      end
      AOD_STYLE_GND: begin
        pin_oe_next = !asserted; // R4 R5
        pin_lo_next = 1'b1;
      end
      AOD_STYLE_PP: begin
        pin_oe_next = 1'b1; // R4 R5
        pin_lo_next = !asserted;
      end
      default: begin
        pin_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_lo_reg <= AOD_PIN_LO_RST;
      pin_oe_reg <= AOD_PIN_OE_RST;
    end else begin
      pin_lo_reg <= pin_lo_next; // R9
      pin_oe_reg <= pin_oe_next;
    end
  end

  always_comb begin
    status = '0;
    status[AOD_ST_PIN_LO] = pin_lo_reg;
    status[AOD_ST_PIN_OE] = pin_oe_reg;
    status[AOD_ST_ASSERT] = asserted;
    status[AOD_ST_AUXIN] = aux_in_level;
    status[AOD_ST_CAPABLE] = capable_reg;
  end

  assign o_pready = pready_reg;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;
  assign o_multipurpose_output_o = pin_lo_reg;
  assign o_multipurpose_output_oe = pin_oe_reg;

endmodule : aod_output_ctrl

// ---- aod_load_model.sv ----
// Model of the load hung on the multipurpose output.
// Assumes oe low leaves the pin floating.
`timescale 1ns/1ps
module aod_load_model (
  input wire logic i_drv,
  input wire logic i_drv_en,
  output logic [1:0] o_state
);
  // 0 floating, 1 pulled to battery_neg_rail, 2 pulled to ground
  assign o_state = !i_drv_en ? 2'h0 : (i_drv ? 2'h2 : 2'h1);
endmodule : aod_load_model

// ---- aod_output_ctrl_properties.sv ----
// Port checks for aod_output_ctrl.
// Assumes one clock and a one-wait-state APB slave.
`timescale 1ns/1ps
module aod_output_ctrl_properties
  import aod_pkg::*;
#(
  parameter int N_SWITCHER = 2,
  parameter int N_LINREG = 2,
  parameter int ADDR_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic [N_SWITCHER*AOD_SEQ_W-1:0] i_switcher_seq_sel,
  input wire logic [N_LINREG*AOD_SEQ_W-1:0] i_linreg_seq_sel,
  input wire logic i_aux_control_input,
  input wire logic o_multipurpose_output_o,
  input wire logic o_multipurpose_output_oe
);
  logic wr_cfg;
  logic no_cap;
  logic oe;
  logic o;
  assign oe = o_multipurpose_output_oe;
  assign o = o_multipurpose_output_o;
  assign wr_cfg = i_psel && i_penable && o_pready && i_pwrite && i_paddr == '0 && i_pstrb[0];
  always_comb begin
    no_cap = 1'b1;
    for (int k = 0; k < N_SWITCHER; k++)
      if (i_switcher_seq_sel[3*k+:3] inside {AOD_SEQ_PIN_LOW, AOD_SEQ_PIN_HIGH})
        no_cap = 1'b0;
    for (int k = 0; k < N_LINREG; k++)
      if (i_linreg_seq_sel[3*k+:3] inside {AOD_SEQ_PIN_LOW, AOD_SEQ_PIN_HIGH})
        no_cap = 1'b0;
  end
  ////////////////////////////////////////
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  off_hiz_a: assert property (wr_cfg && i_pwdata[1:0] == 2'h0 |=> ##1 !oe)
    else $error("style off left the pin driven");
  neg_only_a: assert property (wr_cfg && i_pwdata[1:0] == 2'h1 |=> ##1 !(oe && o))
    else $error("negative-only style pulled to ground");
  gnd_only_a: assert property (wr_cfg && i_pwdata[1:0] == 2'h2 |=> ##1 !(oe && !o))
    else $error("ground-only style pulled to negative rail");
  push_pull_a: assert property (wr_cfg && i_pwdata[1:0] == 2'h3 |=> ##1 oe)
    else $error("push-pull style not driving");
  host_ctl_a: assert property (wr_cfg && i_pwdata[3:0] inside {4'h3, 4'h7}
    |=> ##1 oe && o != $past(i_pwdata[2], 2)) else $error("host assert bit not obeyed");
  pin_ignore_a: assert property (no_cap && !i_psel [*4] |-> $stable(o) && $stable(oe))
    else $error("output moved on a part without pin control");
  pready_wait_a: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
    else $error("ready not after one wait state");
  unmapped_err_a: assert property (o_pready && (i_paddr > 'h8 || i_paddr[1:0] != 2'h0)
    |-> o_pslverr && o_prdata == '0) else $error("unmapped access not refused");
  cover property (wr_cfg && i_pwdata[3] && !no_cap);
  cover property (o_pslverr);
  cover property (oe && !o);
endmodule : aod_output_ctrl_properties
bind aod_output_ctrl aod_output_ctrl_properties #(.N_SWITCHER(N_SWITCHER),
  .N_LINREG(N_LINREG), .ADDR_W(ADDR_W)) aod_output_ctrl_properties_i (.i_ref_clk, .i_rst_b,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata,
  .o_pslverr, .i_switcher_seq_sel, .i_linreg_seq_sel, .i_aux_control_input,
  .o_multipurpose_output_o, .o_multipurpose_output_oe);

// ---- aux_output_drive_control_test.sv ----
// Self-checking bench for aod_output_ctrl with a load model.
// Assumes the aod_output_ctrl defaults of two switchers and two linear regulators.
`timescale 1ns/1ps
module aux_output_drive_control_test;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, i_aux_control_input = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [3:0] i_pstrb = 4'hf;
  logic [5:0] i_switcher_seq_sel = 6'h00, i_linreg_seq_sel = 6'h00;
  logic o_pready, o_pslverr, o_multipurpose_output_o, o_multipurpose_output_oe, er, cap, asrt;
  logic [31:0] o_prdata, rd;
  logic [1:0] load_state, exp_st;
  // Load state per style: {asserted, deasserted}
  logic [3:0] style_row [4] = '{4'h0, 4'h4, 4'h2, 4'h6};
  // {capable, linreg straps, switcher straps}
  logic [12:0] strap_row [3] = '{13'h1030, 13'h1140, 13'h09fc};
  int mismatches = 0;
  int num_checks = 0;
  aod_output_ctrl aod_output_ctrl_i (.i_ref_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata, .o_pslverr, .i_switcher_seq_sel,
    .i_linreg_seq_sel, .i_aux_control_input, .o_multipurpose_output_o, .o_multipurpose_output_oe);
  aod_load_model aod_load_model_i (.i_drv(o_multipurpose_output_o),
    .i_drv_en(o_multipurpose_output_oe), .o_state(load_state));
  always #4 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////
  task chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_ref_clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata, i_pstrb} <= {1'b1, w, a, d, s};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    // Only ready or the watchdog ends a wait for ready
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask : apb
  task close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  initial begin
    for (int p = 0; p < 3; p++) begin
      {cap, i_linreg_seq_sel, i_switcher_seq_sel} <= strap_row[p];
      i_rst_b <= 1'b0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      for (int c = 0; c < 32; c++) begin
        i_aux_control_input <= c[0];
        apb(1'b1, 8'h00, {28'h0, c[4:1]}, 4'hf);
        repeat (8) @(posedge i_ref_clk);
        asrt = (cap && c[4]) ? c[3] == c[0] : c[3];
        exp_st = asrt ? style_row[c[2:1]][3:2] : style_row[c[2:1]][1:0];
        chk(load_state, exp_st);
      end
    end
    i_rst_b <= 1'b0;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h3, 4'he);
    apb(1'b1, 8'h04, 32'hffffffff, 4'hf);
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk({er, rd}, 33'h0);
    apb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, {10'h0, 6'h27, 10'h0, 6'h3c});
    // Status: pin high synced, style off, part not pin-capable
    apb(1'b0, 8'h08, 32'h0, 4'hf);
    chk({er, rd}, {1'b0, 32'h8});
    // Pin low with follow-pin-high setting must not deassert here
    i_aux_control_input <= 1'b0;
    apb(1'b1, 8'h00, 32'hf, 4'hf);
    apb(1'b0, 8'h08, 32'h0, 4'hf);
    chk({er, rd}, {1'b0, 32'h6});
    chk(load_state, 2'h1);
    apb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk({er, rd}, {1'b1, 32'h0});
    close_out();
  end
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule : aux_output_drive_control_test
